// *** verilog/fcs_pkg.sv ***
// Purpose: Shared constants for the flash command sequencer host controller.
// Assumes: Byte-wide flash bus, two erase blocks selected by the top address bit.
// Notes:   Register offsets are byte addresses on the software port.
package fcs_pkg;

  // ---------------------------------------------------------------------------
  // Widths
  // ---------------------------------------------------------------------------
  localparam int ADDR_W = 10;
  localparam int DATA_W = 8;
  localparam int EPOCH_W = 8;
  localparam int MAP_W = EPOCH_W + 1;
  localparam int SYNC_W = DATA_W + 1;
  localparam int BUS_AW = 8;
  localparam int BUS_DW = 32;
  localparam int BLOCK_BIT = ADDR_W - 1;

  // ---------------------------------------------------------------------------
  // Command codes and status byte layout
  // ---------------------------------------------------------------------------
  localparam logic [7:0] CMD_READ_ARRAY = 8'hff;
  localparam logic [7:0] CMD_READ_STATUS = 8'h70;
  localparam logic [7:0] CMD_CLEAR_STATUS = 8'h50;
  localparam logic [7:0] CMD_PROGRAM = 8'h40;
  localparam logic [7:0] CMD_ERASE = 8'h20;
  localparam logic [7:0] CMD_ERASE_CONFIRM = 8'hd0;
  localparam int SR_PROG_ERR_BIT = 4;
  localparam int SR_ERASE_ERR_BIT = 5;
  localparam int SR_READY_BIT = 7;

  // ---------------------------------------------------------------------------
  // Address map of the flash
  // ---------------------------------------------------------------------------
  localparam logic [ADDR_W-1:0] USER_ROM_BASE = 10'h000;
  localparam logic [ADDR_W-1:0] PROT_LO = 10'h3c0;
  localparam logic [ADDR_W-1:0] PROT_HI = 10'h3ff;
  localparam logic [ADDR_W-1:0] INIT_LAST = 10'h3ff;

  // ---------------------------------------------------------------------------
  // Software register map and fields
  // ---------------------------------------------------------------------------
  localparam logic [BUS_AW-1:0] REG_CTRL = 8'h00;
  localparam logic [BUS_AW-1:0] REG_ADDR = 8'h04;
  localparam logic [BUS_AW-1:0] REG_DATA = 8'h08;
  localparam logic [BUS_AW-1:0] REG_CMD = 8'h0c;
  localparam logic [BUS_AW-1:0] REG_STATUS = 8'h10;
  localparam int CTRL_W = 8;
  localparam int CTL_LP_READ = 0;
  localparam int CTL_SUSP_EN = 1;
  localparam int CTL_REWRITE_EN = 2;
  localparam int CTL_B0_LOCK = 3;
  localparam int CTL_B1_LOCK = 4;
  localparam int CTL_EW1 = 5;
  localparam int CTL_ERASE_SUSP = 6;
  localparam int CTL_PROG_SUSP = 7;
  localparam int ST_BUSY = 0;
  localparam int ST_REFUSED = 1;
  localparam int ST_SBYTE_LSB = 8;
  localparam int ST_RBYTE_LSB = 16;
  localparam logic [2:0] RD_WAIT_LAST = 3'h4;

  // ---------------------------------------------------------------------------
  // Operations and sequencer states
  // ---------------------------------------------------------------------------
  typedef enum logic [2:0] {
    OP_READ_ARRAY = 3'b000,
    OP_READ_STATUS = 3'b001,
    OP_CLEAR = 3'b010,
    OP_PROGRAM = 3'b011,
    OP_ERASE = 3'b100
  } fcs_op_e;

  typedef enum logic [2:0] {
    S_INIT = 3'b000,
    S_IDLE = 3'b001,
    S_LOOK = 3'b010,
    S_CYC1 = 3'b011,
    S_GAP = 3'b100,
    S_CYC2 = 3'b101,
    S_WAIT = 3'b110
  } fcs_state_e;

endpackage

// *** verilog/fcs_sync.sv ***
// Purpose: Two-flop synchroniser for the flash read data and the clock source indication.
// Assumes: Each bit is sampled on its own; the bus is read only after it settles.
// Notes:   The first stage feeds nothing but the second stage.
module fcs_sync (
  // Clock and reset
  input wire logic mclk,
  input wire logic reset,
  // Data
  input wire logic [fcs_pkg::SYNC_W-1:0] din,
  output logic [fcs_pkg::SYNC_W-1:0] dout
);

  logic [fcs_pkg::SYNC_W-1:0] meta;

  // Two stages; only the second is visible outside.
  always_ff @(posedge mclk) begin
    if (reset) begin
      meta <= '0;
      dout <= '0;
    end else begin
      meta <= din;
      dout <= meta;
    end
  end

endmodule

// *** verilog/fcs_map_mem.sv ***
// Purpose: One word per flash byte recording the erase epoch it was programmed in.
// Assumes: One write port and one read port; read data come out of a register.
// Notes:   Contents are not reset; the controller clears them after reset.
module fcs_map_mem (
  // Clock
  input wire logic mclk,
  // Write port
  input wire logic we,
  input wire logic [fcs_pkg::ADDR_W-1:0] waddr,
  input wire logic [fcs_pkg::MAP_W-1:0] wdata,
  // Read port
  input wire logic [fcs_pkg::ADDR_W-1:0] raddr,
  output logic [fcs_pkg::MAP_W-1:0] rdata
);

  logic [fcs_pkg::MAP_W-1:0] mem [0:(1 << fcs_pkg::ADDR_W)-1];

  // Registered read keeps the array inferable as block memory.
  always_ff @(posedge mclk) begin
    if (we) begin
      mem[waddr] <= wdata;
    end
    rdata <= mem[raddr];
  end

endmodule

// *** verilog/fcs_host.sv ***
// Purpose: Host controller that issues byte-wide command sequences to the flash.
// Assumes: Flash read data are valid from the cycle after a read strobe until
//          the next strobe; control bits of the flash are driven as pins.
// Notes:   Software gives orders through a small register port.
//
// Implementation choices: the placing of the registers and the address-and-strobe port.
module fcs_host (
  // Clock and reset
  input wire logic mclk,
  input wire logic reset,
  // Software register port
  input wire logic [fcs_pkg::BUS_AW-1:0] addr,
  input wire logic [fcs_pkg::BUS_DW-1:0] wdata,
  input wire logic wr,
  input wire logic rd,
  output logic [fcs_pkg::BUS_DW-1:0] rdata,
  // Flash bus
  output logic [fcs_pkg::ADDR_W-1:0] fl_addr,
  output logic [fcs_pkg::DATA_W-1:0] fl_wdata,
  output logic fl_we,
  output logic fl_re,
  input wire logic [fcs_pkg::DATA_W-1:0] fl_rdata,
  // Flash control pins
  output logic low_power_read_enable,
  output logic suspend_function_enable,
  output logic global_rewrite_enable,
  output logic block0_lock,
  output logic block1_lock,
  output logic interrupt_suspend_rewrite_mode,
  output logic erase_suspend_request,
  output logic program_suspend_request,
  // Clock source indication
  input wire logic osc_low_speed
);

  // ---------------------------------------------------------------------------
  // Declarations
  // ---------------------------------------------------------------------------
  fcs_pkg::fcs_state_e state, next_state;
  fcs_pkg::fcs_op_e op, next_op;
  logic [fcs_pkg::ADDR_W-1:0] cnt, next_cnt;
  logic [fcs_pkg::ADDR_W-1:0] next_fl_addr;
  logic [fcs_pkg::DATA_W-1:0] next_fl_wdata;
  logic next_fl_we, next_fl_re;
  logic [fcs_pkg::ADDR_W-1:0] op_addr, next_op_addr;
  logic [fcs_pkg::DATA_W-1:0] op_data, next_op_data;
  logic refused, next_refused;
  logic [fcs_pkg::DATA_W-1:0] status_byte, next_status_byte;
  logic [fcs_pkg::DATA_W-1:0] read_byte, next_read_byte;
  logic [fcs_pkg::EPOCH_W-1:0] epoch0, next_epoch0, epoch1, next_epoch1;
  logic [fcs_pkg::CTRL_W-1:0] ctrl, next_ctrl;
  logic [fcs_pkg::ADDR_W-1:0] reg_addr, next_reg_addr;
  logic [fcs_pkg::DATA_W-1:0] reg_data, next_reg_data;
  logic [fcs_pkg::BUS_DW-1:0] next_rdata;
  logic [fcs_pkg::SYNC_W-1:0] sync_q;
  logic osc_s;
  logic [fcs_pkg::DATA_W-1:0] fl_rdata_s;
  logic mem_we;
  logic [fcs_pkg::ADDR_W-1:0] mem_waddr;
  logic [fcs_pkg::MAP_W-1:0] mem_wdata, mem_q;
  logic [fcs_pkg::EPOCH_W-1:0] cur_epoch;
  logic map_hit, in_prot, prot_blk, ew1, cmd_wr, refuse, is_read;
  logic [fcs_pkg::DATA_W-1:0] first_code;

  // ---------------------------------------------------------------------------
  // Leaf instances
  // ---------------------------------------------------------------------------
  fcs_sync u_sync (
    .mclk(mclk),
    .reset(reset),
    .din({osc_low_speed, fl_rdata}),
    .dout(sync_q)
  );

  fcs_map_mem u_map (
    .mclk(mclk),
    .we(mem_we),
    .waddr(mem_waddr),
    .wdata(mem_wdata),
    .raddr(reg_addr),
    .rdata(mem_q)
  );

  assign osc_s = sync_q[fcs_pkg::DATA_W];
  assign fl_rdata_s = sync_q[fcs_pkg::DATA_W-1:0];

  // ---------------------------------------------------------------------------
  // Decode of the pending operation
  // ---------------------------------------------------------------------------
  // Epoch comparison stands in for a per-byte clear on erase, which a
  // block memory cannot do in one cycle; an epoch wraps after 256 erases.
  always_comb begin
    ew1 = ctrl[fcs_pkg::CTL_EW1];
    cmd_wr = wr && (addr == fcs_pkg::REG_CMD);
    is_read = (op == fcs_pkg::OP_READ_ARRAY) || (op == fcs_pkg::OP_READ_STATUS);
    cur_epoch = op_addr[fcs_pkg::BLOCK_BIT] ? epoch1 : epoch0;
    map_hit = mem_q[fcs_pkg::EPOCH_W] && (mem_q[fcs_pkg::EPOCH_W-1:0] == cur_epoch);
    in_prot = (op_addr >= fcs_pkg::PROT_LO) && (op_addr <= fcs_pkg::PROT_HI);
    prot_blk = fcs_pkg::PROT_LO[fcs_pkg::BLOCK_BIT];
    refuse = 1'b0;
    first_code = fcs_pkg::CMD_READ_ARRAY;
    case (op)
      fcs_pkg::OP_READ_ARRAY: begin
        first_code = fcs_pkg::CMD_READ_ARRAY;
      end
      fcs_pkg::OP_READ_STATUS: begin
        first_code = fcs_pkg::CMD_READ_STATUS;
        refuse = ew1;
      end
      fcs_pkg::OP_CLEAR: begin
        first_code = fcs_pkg::CMD_CLEAR_STATUS;
      end
      fcs_pkg::OP_PROGRAM: begin
        first_code = fcs_pkg::CMD_PROGRAM;
        refuse = map_hit || (ew1 && in_prot);
      end
      fcs_pkg::OP_ERASE: begin
        first_code = fcs_pkg::CMD_ERASE;
        refuse = program_suspend_request ||
                 (ew1 && (op_addr[fcs_pkg::BLOCK_BIT] == prot_blk));
      end
      default: begin
        refuse = 1'b1;
      end
    endcase
  end

  // ---------------------------------------------------------------------------
  // Sequencer next state
  // ---------------------------------------------------------------------------
  // Each flash bus cycle is one strobe followed by a gap cycle, so the
  // device always sees a quiet cycle between the two halves of a command.
  always_comb begin
    next_state = state;
    next_op = op;
    next_cnt = cnt;
    next_fl_addr = fl_addr;
    next_fl_wdata = fl_wdata;
    next_fl_we = 1'b0;
    next_fl_re = 1'b0;
    next_op_addr = op_addr;
    next_op_data = op_data;
    next_refused = refused;
    next_status_byte = status_byte;
    next_read_byte = read_byte;
    next_epoch0 = epoch0;
    next_epoch1 = epoch1;
    mem_we = 1'b0;
    mem_waddr = op_addr;
    mem_wdata = '0;
    case (state)
      fcs_pkg::S_INIT: begin
        mem_we = 1'b1;
        mem_waddr = cnt;
        next_cnt = cnt + 1'b1;
        if (cnt == fcs_pkg::INIT_LAST) begin
          next_state = fcs_pkg::S_IDLE;
        end
      end
      fcs_pkg::S_IDLE: begin
        if (cmd_wr) begin
          next_op = fcs_pkg::fcs_op_e'(wdata[2:0]);
          next_op_addr = reg_addr;
          next_op_data = reg_data;
          next_refused = 1'b0;
          next_state = fcs_pkg::S_LOOK;
        end
      end
      fcs_pkg::S_LOOK: begin
        if (refuse) begin
          next_refused = 1'b1;
          next_state = fcs_pkg::S_IDLE;
        end else begin
          next_state = fcs_pkg::S_CYC1;
          next_fl_we = 1'b1;
          next_fl_wdata = first_code;
          next_fl_addr = (op == fcs_pkg::OP_PROGRAM || op == fcs_pkg::OP_ERASE) ?
                         op_addr : fcs_pkg::USER_ROM_BASE;
        end
      end
      fcs_pkg::S_CYC1: begin
        next_state = fcs_pkg::S_GAP;
      end
      fcs_pkg::S_GAP: begin
        if (op == fcs_pkg::OP_CLEAR) begin
          next_state = fcs_pkg::S_IDLE;
        end else if (is_read) begin
          next_state = fcs_pkg::S_CYC2;
          next_fl_re = 1'b1;
          next_fl_addr = (op == fcs_pkg::OP_READ_ARRAY) ? op_addr : fcs_pkg::USER_ROM_BASE;
        end else begin
          next_state = fcs_pkg::S_CYC2;
          next_fl_we = 1'b1;
          next_fl_addr = op_addr;
          next_fl_wdata = (op == fcs_pkg::OP_PROGRAM) ? op_data : fcs_pkg::CMD_ERASE_CONFIRM;
        end
      end
      fcs_pkg::S_CYC2: begin
        next_cnt = '0;
        next_state = is_read ? fcs_pkg::S_WAIT : fcs_pkg::S_IDLE;
        if (op == fcs_pkg::OP_PROGRAM) begin
          mem_we = 1'b1;
          mem_wdata = {1'b1, cur_epoch};
        end else if (op == fcs_pkg::OP_ERASE && op_addr[fcs_pkg::BLOCK_BIT]) begin
          next_epoch1 = epoch1 + 1'b1;
        end else if (op == fcs_pkg::OP_ERASE) begin
          next_epoch0 = epoch0 + 1'b1;
        end
      end
      fcs_pkg::S_WAIT: begin
        next_cnt = cnt + 1'b1;
        if (cnt[2:0] == fcs_pkg::RD_WAIT_LAST) begin
          next_state = fcs_pkg::S_IDLE;
          if (op == fcs_pkg::OP_READ_STATUS) begin
            next_status_byte = fl_rdata_s;
          end else begin
            next_read_byte = fl_rdata_s;
          end
        end
      end
      default: begin
        next_state = fcs_pkg::S_IDLE;
      end
    endcase
    // A command while busy is dropped and flagged.
    if (cmd_wr && state != fcs_pkg::S_IDLE) begin
      next_refused = 1'b1;
    end
  end

  // Sequencer registers.
  always_ff @(posedge mclk) begin
    if (reset) begin
      state <= fcs_pkg::S_INIT;
      op <= fcs_pkg::OP_READ_ARRAY;
      cnt <= '0;
      fl_addr <= '0;
      fl_wdata <= '0;
      fl_we <= 1'b0;
      fl_re <= 1'b0;
      op_addr <= '0;
      op_data <= '0;
      refused <= 1'b0;
      status_byte <= '0;
      read_byte <= '0;
      epoch0 <= '0;
      epoch1 <= '0;
    end else begin
      state <= next_state;
      op <= next_op;
      cnt <= next_cnt;
      fl_addr <= next_fl_addr;
      fl_wdata <= next_fl_wdata;
      fl_we <= next_fl_we;
      fl_re <= next_fl_re;
      op_addr <= next_op_addr;
      op_data <= next_op_data;
      refused <= next_refused;
      status_byte <= next_status_byte;
      read_byte <= next_read_byte;
      epoch0 <= next_epoch0;
      epoch1 <= next_epoch1;
    end
  end

  // ---------------------------------------------------------------------------
  // Software register port
  // ---------------------------------------------------------------------------
  // Suspend bits follow the enable; in interrupt mode software may only
  // clear them, which keeps this host from fighting the device's own set.
  always_comb begin
    next_ctrl = ctrl;
    next_reg_addr = reg_addr;
    next_reg_data = reg_data;
    next_rdata = '0;
    if (wr && addr == fcs_pkg::REG_CTRL) begin
      next_ctrl = wdata[fcs_pkg::CTRL_W-1:0];
      if (ew1) begin
        next_ctrl[fcs_pkg::CTL_ERASE_SUSP] = ctrl[fcs_pkg::CTL_ERASE_SUSP] &
                                              wdata[fcs_pkg::CTL_ERASE_SUSP];
        next_ctrl[fcs_pkg::CTL_PROG_SUSP] = ctrl[fcs_pkg::CTL_PROG_SUSP] &
                                             wdata[fcs_pkg::CTL_PROG_SUSP];
      end
    end
    if (wr && addr == fcs_pkg::REG_ADDR) begin
      next_reg_addr = wdata[fcs_pkg::ADDR_W-1:0];
    end
    if (wr && addr == fcs_pkg::REG_DATA) begin
      next_reg_data = wdata[fcs_pkg::DATA_W-1:0];
    end
    next_ctrl[fcs_pkg::CTL_LP_READ] = next_ctrl[fcs_pkg::CTL_LP_READ] & osc_s;
    next_ctrl[fcs_pkg::CTL_ERASE_SUSP] = next_ctrl[fcs_pkg::CTL_ERASE_SUSP] &
                                          next_ctrl[fcs_pkg::CTL_SUSP_EN];
    next_ctrl[fcs_pkg::CTL_PROG_SUSP] = next_ctrl[fcs_pkg::CTL_PROG_SUSP] &
                                         next_ctrl[fcs_pkg::CTL_SUSP_EN];
    if (rd) begin
      case (addr)
        fcs_pkg::REG_CTRL: next_rdata[fcs_pkg::CTRL_W-1:0] = ctrl;
        fcs_pkg::REG_ADDR: next_rdata[fcs_pkg::ADDR_W-1:0] = reg_addr;
        fcs_pkg::REG_DATA: next_rdata[fcs_pkg::DATA_W-1:0] = reg_data;
        fcs_pkg::REG_STATUS: begin
          next_rdata[fcs_pkg::ST_BUSY] = (state != fcs_pkg::S_IDLE);
          next_rdata[fcs_pkg::ST_REFUSED] = refused;
          next_rdata[fcs_pkg::ST_SBYTE_LSB +: fcs_pkg::DATA_W] = status_byte;
          next_rdata[fcs_pkg::ST_RBYTE_LSB +: fcs_pkg::DATA_W] = read_byte;
        end
        default: next_rdata = '0;
      endcase
    end
  end

  // Register port state.
  always_ff @(posedge mclk) begin
    if (reset) begin
      ctrl <= '0;
      reg_addr <= '0;
      reg_data <= '0;
      rdata <= '0;
    end else begin
      ctrl <= next_ctrl;
      reg_addr <= next_reg_addr;
      reg_data <= next_reg_data;
      rdata <= next_rdata;
    end
  end

  assign low_power_read_enable = ctrl[fcs_pkg::CTL_LP_READ];
  assign suspend_function_enable = ctrl[fcs_pkg::CTL_SUSP_EN];
  assign global_rewrite_enable = ctrl[fcs_pkg::CTL_REWRITE_EN];
  assign block0_lock = ctrl[fcs_pkg::CTL_B0_LOCK];
  assign block1_lock = ctrl[fcs_pkg::CTL_B1_LOCK];
  assign interrupt_suspend_rewrite_mode = ctrl[fcs_pkg::CTL_EW1];
  assign erase_suspend_request = ctrl[fcs_pkg::CTL_ERASE_SUSP];
  assign program_suspend_request = ctrl[fcs_pkg::CTL_PROG_SUSP];

  // ---------------------------------------------------------------------------
  // Assertions
  // ---------------------------------------------------------------------------
  default clocking cb @(posedge mclk); endclocking
  default disable iff (reset);

  sequence s_first_write(logic [7:0] code);
    state == fcs_pkg::S_CYC1 && fl_we && fl_wdata == code;
  endsequence

  property p_prog_pair;
    s_first_write(fcs_pkg::CMD_PROGRAM) ##1 !fl_we ##1 fl_we
      |-> fl_addr == $past(fl_addr, 2) && fl_wdata == op_data;
  endproperty
  a_prog_pair: assert property (p_prog_pair) else $error("program address changed");

  property p_erase_pair;
    s_first_write(fcs_pkg::CMD_ERASE) |-> ##2 (fl_we && fl_wdata == fcs_pkg::CMD_ERASE_CONFIRM);
  endproperty
  a_erase_pair: assert property (p_erase_pair) else $error("erase confirm missing");

  property p_status_addr;
    fl_re && op == fcs_pkg::OP_READ_STATUS |-> fl_addr == fcs_pkg::USER_ROM_BASE ##5 !fl_re;
  endproperty
  a_status_addr: assert property (p_status_addr) else $error("status read address");

  property p_no_status_ew1;
    s_first_write(fcs_pkg::CMD_READ_STATUS) |-> !$past(ew1, 2);
  endproperty
  a_no_status_ew1: assert property (p_no_status_ew1) else $error("status in ew1");

  property p_lp_osc;
    !osc_s |=> !low_power_read_enable;
  endproperty
  a_lp_osc: assert property (p_lp_osc) else $error("low-power read on fast clock");

  property p_no_reprogram;
    state == fcs_pkg::S_LOOK && op == fcs_pkg::OP_PROGRAM && map_hit |=> refused && !fl_we;
  endproperty
  a_no_reprogram: assert property (p_no_reprogram) else $error("reprogram issued");

  property p_no_erase_susp;
    s_first_write(fcs_pkg::CMD_ERASE) |-> !$past(program_suspend_request);
  endproperty
  a_no_erase_susp: assert property (p_no_erase_susp) else $error("erase in suspend");

  property p_prot_code;
    s_first_write(fcs_pkg::CMD_PROGRAM) ##0 $past(ew1) |-> !(fl_addr >= fcs_pkg::PROT_LO);
  endproperty
  a_prot_code: assert property (p_prot_code) else $error("control code rewritten");

  property p_ew0_suspend;
    wr && addr == fcs_pkg::REG_CTRL && !ew1 && wdata[fcs_pkg::CTL_SUSP_EN] &&
      wdata[fcs_pkg::CTL_ERASE_SUSP] |=> erase_suspend_request;
  endproperty
  a_ew0_suspend: assert property (p_ew0_suspend) else $error("suspend write lost");

  property p_byte_code;
    state == fcs_pkg::S_CYC1 |-> fl_we && !fl_re && (fl_wdata == fcs_pkg::CMD_READ_ARRAY ||
      fl_wdata == fcs_pkg::CMD_READ_STATUS || fl_wdata == fcs_pkg::CMD_CLEAR_STATUS ||
      fl_wdata == fcs_pkg::CMD_PROGRAM || fl_wdata == fcs_pkg::CMD_ERASE);
  endproperty
  a_byte_code: assert property (p_byte_code) else $error("bad command byte");

endmodule

// *** sim/fcs_flash_model.sv ***
// Purpose: Behavioural flash device that answers the host's byte-wide command cycles.
// Assumes: Operations finish at once, so the ready bit always reads 1.
// Notes:   Read data stand until the next write strobe, then go to the inverse.
module fcs_flash_model (
  // Clock
  input wire logic mclk,
  // Flash bus
  input wire logic [9:0] fl_addr,
  input wire logic [7:0] fl_wdata,
  input wire logic fl_we,
  input wire logic fl_re,
  output logic [7:0] fl_rdata,
  // Protection pins
  input wire logic global_rewrite_enable,
  input wire logic block0_lock,
  input wire logic block1_lock
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [7:0] mem [1024];
  logic [7:0] pend = 8'h00;
  logic stat_mode = 1'b0;
  logic [1:0] err = 2'h0;
  logic lock;
  initial foreach (mem[i]) mem[i] = 8'hff;
  initial fl_rdata = 8'h00;
  // Suspend pins are not watched: no operation is ever left running.
  assign lock = fl_addr[9] ? block1_lock : (!global_rewrite_enable || block0_lock);
  // One byte per strobe; a rejected rewrite is a command sequence error.
  always @(posedge mclk) begin
    if (fl_we) begin
      fl_rdata <= ~fl_rdata;
      pend <= 8'h00;
      if (pend == 8'h40) begin
        stat_mode <= 1'b1;
        if (lock) err <= 2'h3;
        else if (err == 2'h0) mem[fl_addr] <= fl_wdata & mem[fl_addr];
      // erase outcome; fails on a locked block or a confirm byte other than d0 or ff
      end else if (pend == 8'h20) begin
        stat_mode <= 1'b1;
        if ((fl_wdata != 8'hd0 && fl_wdata != 8'hff) || lock) err <= 2'h3;
        else if (err == 2'h0) for (int i = 0; i < 1024; i++)
          if (i[9] == fl_addr[9]) mem[i] <= 8'hff;
      end else if (fl_wdata == 8'hff) stat_mode <= 1'b0;
      else if (fl_wdata == 8'h70) stat_mode <= 1'b1;
      else if (fl_wdata == 8'h50) err <= 2'h0;
      else pend <= fl_wdata;
    end
    if (fl_re) fl_rdata <= stat_mode ? {2'b10, err, 4'h0} : mem[fl_addr];
  end
endmodule

// *** sim/tb_top.sv ***
// Purpose: Self-checking bench for the flash host controller.
// Assumes: The slow oscillator runs except in one short stretch.
// Notes:   Expected bytes come from a shadow array kept here.
module tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  logic mclk = 1'b0;
  logic reset = 1'b1;
  logic [7:0] addr = 8'h00;
  logic [31:0] wdata = 32'h0;
  logic wr = 1'b0;
  logic rd = 1'b0;
  logic osc_low_speed = 1'b1;
  logic [31:0] rdata;
  logic [31:0] st;
  logic [9:0] fl_addr;
  logic [9:0] a;
  logic [7:0] fl_wdata;
  logic [7:0] fl_rdata;
  logic [7:0] d;
  logic fl_we;
  logic fl_re;
  logic [7:0] pins;
  logic [7:0] exp_mem [1024];
  logic [7:0] lk [3] = '{8'h00, 8'h0c, 8'h14};
  logic [7:0] cv [3] = '{8'hc5, 8'h26, 8'he6};
  logic [7:0] cx [3] = '{8'h05, 8'h26, 8'h26};
  int num_errors = 0;
  int num_checks = 0;
  always #2.5 mclk = ~mclk;
  fcs_host dut (.mclk(mclk), .reset(reset), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd),
    .rdata(rdata), .fl_addr(fl_addr), .fl_wdata(fl_wdata), .fl_we(fl_we), .fl_re(fl_re),
    .fl_rdata(fl_rdata), .low_power_read_enable(pins[0]), .suspend_function_enable(pins[1]),
    .global_rewrite_enable(pins[2]), .block0_lock(pins[3]), .block1_lock(pins[4]),
    .interrupt_suspend_rewrite_mode(pins[5]), .erase_suspend_request(pins[6]),
    .program_suspend_request(pins[7]), .osc_low_speed(osc_low_speed));
  fcs_flash_model flash (.mclk(mclk), .fl_addr(fl_addr), .fl_wdata(fl_wdata), .fl_we(fl_we),
    .fl_re(fl_re), .fl_rdata(fl_rdata), .global_rewrite_enable(pins[2]),
    .block0_lock(pins[3]), .block1_lock(pins[4]));
  task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp) begin
      num_errors++;
      $display("unexpected %s: expected %h, seen %h", name, exp, seen);
    end
  endtask
  task automatic wr_reg(input logic [7:0] ad, input logic [31:0] v);
    @(posedge mclk);
    addr <= ad;
    wdata <= v;
    wr <= 1'b1;
    @(posedge mclk);
    wr <= 1'b0;
  endtask
  task automatic rd_reg(input logic [7:0] ad, output logic [31:0] v);
    @(posedge mclk);
    addr <= ad;
    rd <= 1'b1;
    @(posedge mclk);
    rd <= 1'b0;
    @(negedge mclk);
    v = rdata;
  endtask
  // Polls busy under a bound, leaving the last status word in s.
  task automatic idle(output logic [31:0] s);
    for (int n = 0; n < 600; n++) begin
      rd_reg(fcs_pkg::REG_STATUS, s);
      if (s[0] === 1'b0) return;
    end
    chk("busy", s[0], 0);
  endtask
  task automatic run(input logic [2:0] c, input logic [9:0] ad, input logic [7:0] v);
    wr_reg(fcs_pkg::REG_ADDR, {22'h0, ad});
    wr_reg(fcs_pkg::REG_DATA, {24'h0, v});
    wr_reg(fcs_pkg::REG_CMD, {29'h0, c});
    idle(st);
  endtask
  task automatic conclude();
    $display("checks %0d errors %0d", num_checks, num_errors);
    if (num_errors == 0 && num_checks > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  initial begin
    repeat (60000) @(posedge mclk);
    num_errors++;
    conclude();
  end
  initial begin
    void'($urandom(96353));
    foreach (exp_mem[i]) exp_mem[i] = 8'hff;
    repeat (16) @(posedge mclk);
    reset <= 1'b0;
    idle(st);
    wr_reg(fcs_pkg::REG_CTRL, 32'h04);
    for (int k = 0; k < 4; k++) begin
      a = 10'(k * 64 + $urandom_range(63));
      d = 8'($urandom);
      exp_mem[a] = d;
      run(3, a, d);
      run(0, a, 8'h00);
      chk("array byte", st[23:16], exp_mem[a]);
      run(1, 10'h000, 8'h00);
      chk("status byte", st[15:8], 8'h80);
    end
    run(3, a, d);
    chk("reprogram refused", st[1], 1);
    run(4, 10'h010, 8'h00);
    run(0, a, 8'h00);
    chk("erased byte", st[23:16], 8'hff);
    for (int k = 0; k < 3; k++) begin
      wr_reg(fcs_pkg::REG_CTRL, {24'h0, lk[k]});
      a = (k == 2) ? 10'h210 : 10'(10'h100 + k);
      run(3, a, 8'h5a);
      run(1, 10'h000, 8'h00);
      chk("locked status", st[15:8], 8'hb0);
      wr_reg(fcs_pkg::REG_CTRL, 32'h04);
      run(3, a + 10'h020, 8'h5a);
      run(0, a + 10'h020, 8'h00);
      chk("blocked program", st[23:16], 8'hff);
      run(2, 10'h000, 8'h00);
      run(1, 10'h000, 8'h00);
      chk("cleared status", st[15:8], 8'h80);
    end
    wr_reg(fcs_pkg::REG_CTRL, 32'hc6);
    repeat (4) @(posedge mclk);
    chk("suspend pins", pins, 8'hc6);
    run(4, 10'h010, 8'h00);
    chk("erase in suspend", st[1], 1);
    @(posedge mclk);
    osc_low_speed <= 1'b0;
    wr_reg(fcs_pkg::REG_CTRL, 32'h05);
    repeat (4) @(posedge mclk);
    chk("fast clock pins", pins, 8'h04);
    osc_low_speed <= 1'b1;
    repeat (2) @(posedge mclk);
    for (int k = 0; k < 3; k++) begin
      wr_reg(fcs_pkg::REG_CTRL, {24'h0, cv[k]});
      repeat (4) @(posedge mclk);
      chk("control pins", pins, cx[k]);
    end
    run(1, 10'h000, 8'h00);
    chk("status in ew1", st[1], 1);
    run(4, 10'h3c5, 8'h00);
    chk("erase in ew1", st[1], 1);
    run(3, 10'h3d0, 8'h00);
    chk("program in ew1", st[1], 1);
    rd_reg(8'h14, st);
    chk("unmapped", st, 0);
    conclude();
  end
endmodule
